/* core/adcs_fifo.sv */
// Flop-based FIFO with valid/ready on both sides
`timescale 1ns/10ps
module adcs_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] wr_ptr_d;
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] rd_ptr_d;
    logic [AW:0]   count_q;
    logic [AW:0]   count_d;
    logic          in_ready_q;
    logic          in_ready_d;
    logic          push;
    logic          pop;

    // Pointer and count update; ready registered so it is a clean flop output
    always_comb begin
        push       = in_valid && in_ready_q;
        pop        = out_ready && (count_q != '0);
        wr_ptr_d   = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d   = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d    = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        in_ready_d = (count_d != FULL_CNT);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b0;
        end else begin
            wr_ptr_q   <= wr_ptr_d;
            rd_ptr_q   <= rd_ptr_d;
            count_q    <= count_d;
            in_ready_q <= in_ready_d;
        end
    end

    // Storage needs no reset, only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    assign in_ready  = in_ready_q;
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];

endmodule : adcs_fifo

/* core/adcs_pkg.sv */
// Shared constants and types for the converter serial configuration and status port
package adcs_pkg;

    // Frame layout
    localparam int RES_W      = 16;            // Conversion result bits
    localparam int STAT_W     = 6;             // Appended status bits
    localparam int FRAME_W    = RES_W + STAT_W;
    localparam int CMD_W      = 8;             // Access command byte
    localparam int CFG_W      = 8;             // Configuration register width
    localparam int CNT_W      = 5;             // Edge counters, enough for 22

    // Edge numbers that close parts of a frame
    localparam logic [CNT_W-1:0] CMD_LAST_RISE  = 5'h07;  // 8th rising edge, zero based
    localparam logic [CNT_W-1:0] DATA_LAST_RISE = 5'h0f;  // 16th rising edge, zero based
    localparam logic [CNT_W-1:0] RISE_SAT       = 5'h10;
    localparam logic [CNT_W-1:0] RD_FIRST_BIT   = 5'h08;  // First readback bit index
    localparam logic [CNT_W-1:0] RD_LAST_BIT    = 5'h0f;  // Last readback bit index
    localparam logic [CNT_W-1:0] END_NO_STAT    = 5'h10;  // Release after 16th falling edge
    localparam logic [CNT_W-1:0] END_WITH_STAT  = 5'h16;  // Release after 22nd falling edge

    // Access command byte fields
    localparam int         CMD_EN_N_POS = 7;     // Active-low access enable
    localparam int         CMD_RD_POS   = 6;     // 1 selects read, 0 selects write
    localparam logic [5:0] CMD_TAG      = 6'h14; // Fixed pattern 0,1,0,1,0,0

    // Configuration register fields
    localparam int CFG_STAT_EN_POS = 4;
    localparam int CFG_SPAN_POS    = 3;
    localparam int CFG_HIZ_POS     = 2;
    localparam int CFG_TURBO_POS   = 1;
    localparam int CFG_FLAG_POS    = 0;
    localparam logic [3:0] CFG_RW_RESET  = 4'h0;  // Bits 4:1 after reset
    localparam logic       CFG_FLAG_RESET = 1'b1; // No clamp event seen
    localparam logic [2:0] CFG_RSVD       = 3'h0; // Bits 7:5 read as zero
    localparam logic [1:0] STAT_RSVD      = 2'h0; // Status bits 1:0

    // Buffering of results between the conversion core and the link
    localparam int FIFO_DEPTH = 32;

    // Host serial clock floor at top turbo throughput, in MHz
    localparam int SCK_MIN_TURBO_MHZ      = 70;
    localparam int SCK_MIN_TURBO_STAT_MHZ = 93;

    // Frame sequencing
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_SHIFT    = 2'b01,
        ST_RELEASED = 2'b10
    } adcs_state_t;

endpackage : adcs_pkg

/* core/adcs_port.sv */
// Serial port of the converter: result readout, status bits, configuration access
// How it works
// RULE1: Access is command byte then data byte.
// RULE2: Host holds select low for whole access.
// RULE3: Sample input on rise, change output on fall.
// RULE4: Select high releases the serial output.
// RULE5: First input bit zero enables access.
// RULE6: Second command bit picks read or write.
// RULE7: Six command bits must equal fixed pattern.
// RULE8: Write takes MSB first, applies after eight bits.
// RULE9: Read shifts configuration out MSB first.
// RULE10: Host skips reads when daisy-chained.
// RULE11: Configuration bit zero ignores writes.
// RULE12: Write may share frame with result readout.
// RULE13: Status enabled appends six bits per result.
// RULE14: Status MSB first, right after result LSB.
// RULE15: Output released after sixth status bit.
// RULE16: Partial status readout is tolerated.
// RULE17: Daisy-chain host clocks all six status bits.
// RULE18: Status: flag, span, high-Z, turbo, two reserved.
// RULE19: Turbo clock floor uses post-start quiet time.
// RULE20: Non-turbo floor uses conversion time instead.
// RULE21: Top turbo rate needs 70 or 93 MHz.
// RULE22: Enables at bits 4..1, reset zero, 7:5 reserved.
// RULE23: Bit zero sticky active-low clamp flag.
// RULE24: Host uses clock polarity and phase zero.
// RULE25: Bad command leaves configuration untouched.
`timescale 1ns/10ps
module adcs_port
    import adcs_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      sclk_pin,
    input  wire logic                      start_select_line,
    input  wire logic                      sdi_pin,
    output logic                           sdo_o,
    output logic                           sdo_oe_n,
    input  wire logic [adcs_pkg::RES_W-1:0] conv_data,
    input  wire logic                      conv_valid,
    output logic                           conv_ready,
    input  wire logic                      clamp_event,
    output logic                           conv_start,
    output logic                           status_bits_en,
    output logic                           span_comp_en,
    output logic                           high_z_en,
    output logic                           turbo_en,
    output logic                           input_clamp_event_flag_n,
    output logic                           reg_write_done,
    output logic                           frame_ignored
);

    // Synchronised pins and their previous values
    logic [2:0]           pins_sync;
    logic                 sclk_s;
    logic                 sel_s;
    logic                 sdi_s;
    logic                 sclk_prev_q;
    logic                 sel_prev_q;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 sel_fall;
    logic                 sel_rise;

    // Result buffer read side
    logic [RES_W-1:0]     fifo_data;
    logic                 fifo_valid;
    logic                 fifo_pop;

    // Frame state
    adcs_state_t          st_q;
    adcs_state_t          st_d;
    logic [CNT_W-1:0]     rise_cnt_q;
    logic [CNT_W-1:0]     rise_cnt_d;
    logic [CNT_W-1:0]     fall_cnt_q;
    logic [CNT_W-1:0]     fall_cnt_d;
    logic [CMD_W-1:0]     sin_q;
    logic [CMD_W-1:0]     sin_d;
    logic [FRAME_W-1:0]   word_q;
    logic [FRAME_W-1:0]   word_d;
    logic                 stat_frame_q;
    logic                 stat_frame_d;
    logic                 cmd_ok_q;
    logic                 cmd_ok_d;
    logic                 rd_mode_q;
    logic                 rd_mode_d;
    logic                 sdo_q;
    logic                 sdo_d;
    logic                 oe_n_q;
    logic                 oe_n_d;
    logic                 start_q;
    logic                 start_d;
    logic                 wr_done_q;
    logic                 wr_done_d;
    logic                 ignored_q;
    logic                 ignored_d;

    // Configuration register
    logic [3:0]           cfg_rw_q;
    logic [3:0]           cfg_rw_d;
    logic                 flag_n_q;
    logic                 flag_n_d;
    logic [CFG_W-1:0]     cfg_full;
    logic [STAT_W-1:0]    stat_word;
    logic                 read_done;

    // Working variables of the next-state process
    logic [CMD_W-1:0]     byte_in;
    logic [CNT_W-1:0]     fall_next;
    logic [CNT_W-1:0]     last_fall;

    // Link clock, select and data in pass two flops before any use
    adcs_sync #(
        .W        (3)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({sclk_pin, start_select_line, sdi_pin}),
        .sync_out (pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign sel_s  = pins_sync[1];
    assign sdi_s  = pins_sync[0];

    // Results wait here until the host opens a frame
    adcs_fifo #(
        .W         (RES_W),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (conv_data),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Edge detection on the synchronised copies
    always_comb begin
        sclk_rise = sclk_s && !sclk_prev_q;
        sclk_fall = !sclk_s && sclk_prev_q;
        sel_fall  = !sel_s && sel_prev_q;
        sel_rise  = sel_s && !sel_prev_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b0;  // Matches synchroniser reset, so no false frame after reset
        end else begin
            sclk_prev_q <= sclk_s;
            sel_prev_q  <= sel_s;
        end
    end

    // Register image and status image
    always_comb begin
        cfg_full  = {CFG_RSVD, cfg_rw_q, flag_n_q};                              // RULE22
        stat_word = {flag_n_q, cfg_rw_q[CFG_SPAN_POS-1], cfg_rw_q[CFG_HIZ_POS-1],
                     cfg_rw_q[CFG_TURBO_POS-1], STAT_RSVD};                        // RULE18
    end

    // Frame sequencing, shifting and configuration update
    always_comb begin
        st_d         = st_q;
        rise_cnt_d   = rise_cnt_q;
        fall_cnt_d   = fall_cnt_q;
        sin_d        = sin_q;
        word_d       = word_q;
        stat_frame_d = stat_frame_q;
        cmd_ok_d     = cmd_ok_q;
        rd_mode_d    = rd_mode_q;
        sdo_d        = sdo_q;
        oe_n_d       = oe_n_q;
        cfg_rw_d     = cfg_rw_q;
        start_d      = 1'b0;
        wr_done_d    = 1'b0;
        ignored_d    = 1'b0;
        fifo_pop     = 1'b0;
        read_done    = 1'b0;
        byte_in      = {sin_q[CMD_W-2:0], sdi_s};
        fall_next    = fall_cnt_q + 5'h01;
        last_fall    = stat_frame_q ? END_WITH_STAT : END_NO_STAT;                 // RULE13

        case (st_q)
            ST_IDLE: begin
                // Select low opens a frame; MSB goes out at once
                if (sel_fall) begin
                    st_d         = ST_SHIFT;
                    rise_cnt_d   = '0;
                    fall_cnt_d   = '0;
                    sin_d        = '0;
                    cmd_ok_d     = 1'b0;
                    rd_mode_d    = 1'b0;
                    stat_frame_d = cfg_rw_q[CFG_STAT_EN_POS-1];
                    word_d       = {fifo_valid ? fifo_data : word_q[FRAME_W-1:STAT_W], stat_word};
                    fifo_pop     = fifo_valid;
                    sdo_d        = fifo_valid ? fifo_data[RES_W-1] : word_q[FRAME_W-1];
                    oe_n_d       = 1'b0;
                end
            end
            ST_SHIFT, ST_RELEASED: begin
                if (sel_rise) begin
                    // Select high ends any frame, read or not
                    st_d    = ST_IDLE;
                    oe_n_d  = 1'b1;                                                // RULE4
                    start_d = 1'b1;                                                // RULE16
                end else if (sclk_rise && rise_cnt_q != RISE_SAT) begin
                    sin_d      = byte_in;                                          // RULE3
                    rise_cnt_d = rise_cnt_q + 5'h01;
                    if (rise_cnt_q == CMD_LAST_RISE) begin
                        // Command byte complete
                        cmd_ok_d  = !byte_in[CMD_EN_N_POS]                         // RULE5
                                    && (byte_in[5:0] == CMD_TAG);                  // RULE7
                        rd_mode_d = cmd_ok_d && byte_in[CMD_RD_POS];               // RULE6
                        ignored_d = !cmd_ok_d;                                     // RULE25
                    end else if (rise_cnt_q == DATA_LAST_RISE && cmd_ok_q && !rd_mode_q) begin
                        // Whole data byte in; bit zero is not writable
                        cfg_rw_d  = byte_in[CFG_STAT_EN_POS:CFG_TURBO_POS];         // RULE8 RULE11 RULE1
                        wr_done_d = 1'b1;                                          // RULE12
                    end
                end else if (sclk_fall && st_q == ST_SHIFT) begin
                    fall_cnt_d = fall_next;
                    if (fall_next == last_fall) begin
                        st_d   = ST_RELEASED;
                        oe_n_d = 1'b1;                                             // RULE15
                    end else if (rd_mode_q && fall_next >= RD_FIRST_BIT && fall_next <= RD_LAST_BIT) begin
                        sdo_d     = cfg_full[RD_LAST_BIT[2:0] - fall_next[2:0]];   // RULE9
                        read_done = (fall_next == RD_LAST_BIT);
                    end else begin
                        sdo_d = word_q[5'(FRAME_W - 1) - fall_next];               // RULE14 RULE3
                    end
                end
            end
            default: begin
                st_d   = ST_IDLE;
                oe_n_d = 1'b1;
            end
        endcase

        // Clamp event holds the flag low; a finished read restores it after the event
        if (clamp_event) begin
            flag_n_d = 1'b0;                                                       // RULE23
        end else if (read_done) begin
            flag_n_d = 1'b1;                                                       // RULE23
        end else begin
            flag_n_d = flag_n_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q         <= ST_IDLE;
            rise_cnt_q   <= '0;
            fall_cnt_q   <= '0;
            sin_q        <= '0;
            word_q       <= '0;
            stat_frame_q <= 1'b0;
            cmd_ok_q     <= 1'b0;
            rd_mode_q    <= 1'b0;
            sdo_q        <= 1'b0;
            oe_n_q       <= 1'b1;
            start_q      <= 1'b0;
            wr_done_q    <= 1'b0;
            ignored_q    <= 1'b0;
            cfg_rw_q     <= CFG_RW_RESET;                                          // RULE22
            flag_n_q     <= CFG_FLAG_RESET;
        end else begin
            st_q         <= st_d;
            rise_cnt_q   <= rise_cnt_d;
            fall_cnt_q   <= fall_cnt_d;
            sin_q        <= sin_d;
            word_q       <= word_d;
            stat_frame_q <= stat_frame_d;
            cmd_ok_q     <= cmd_ok_d;
            rd_mode_q    <= rd_mode_d;
            sdo_q        <= sdo_d;
            oe_n_q       <= oe_n_d;
            start_q      <= start_d;
            wr_done_q    <= wr_done_d;
            ignored_q    <= ignored_d;
            cfg_rw_q     <= cfg_rw_d;
            flag_n_q     <= flag_n_d;
        end
    end

    // All outputs straight from flops
    assign sdo_o                    = sdo_q;
    assign sdo_oe_n                 = oe_n_q;
    assign conv_start               = start_q;
    assign reg_write_done           = wr_done_q;
    assign frame_ignored            = ignored_q;
    assign status_bits_en           = cfg_rw_q[CFG_STAT_EN_POS-1];
    assign span_comp_en             = cfg_rw_q[CFG_SPAN_POS-1];
    assign high_z_en                = cfg_rw_q[CFG_HIZ_POS-1];
    assign turbo_en                 = cfg_rw_q[CFG_TURBO_POS-1];
    assign input_clamp_event_flag_n = flag_n_q;

endmodule : adcs_port

/* core/adcs_sync.sv */
// Two-stage synchroniser, one chain per bit
`timescale 1ns/10ps
module adcs_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // One chain per input bit; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                meta_d[i] = async_in[i];
                sync_d[i] = meta_q[i];
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= meta_d[i];
                    sync_q[i] <= sync_d[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;

endmodule : adcs_sync

/* sim/adcs_host_model.sv */
// Behavioural serial host, clock polarity and phase zero
`timescale 1ns/10ps
module adcs_host_model (
    input  wire logic        go,
    input  wire logic [4:0]  nbits,
    input  wire logic [21:0] tx,
    output logic      [21:0] rx,
    output logic             done,
    output logic             sclk_pin,
    output logic             start_select_line,
    output logic             sdi_pin,
    input  wire logic        sdo_o,
    input  wire logic        sdo_oe_n
);
    logic last_q;
    logic sdo_line;
    // Released line floats; show the inverse of the last driven bit
    always @(sdo_o or sdo_oe_n) if (!sdo_oe_n) last_q = sdo_o;
    assign sdo_line = sdo_oe_n ? ~last_q : sdo_o;
    // One frame per request; clock stands low between frames, no daisy chain
    initial begin
        sclk_pin = 1'b0;
        start_select_line = 1'b1;
        sdi_pin = 1'b1;
        done = 1'b0;
        rx = 22'h0;
        forever begin
            wait (go);
            #30 start_select_line = 1'b0;
            for (int i = 0; i < nbits; i++) begin
                sdi_pin = tx[21-i];
                #400 sclk_pin = 1'b1;
                // Sample late in the high phase, well clear of the output update
                #400 rx[21-i] = sdo_line;
                sclk_pin = 1'b0;
            end
            sdi_pin = 1'b1;
            #400 start_select_line = 1'b1;
            #400 done = 1'b1;
            wait (!go);
            done = 1'b0;
        end
    end
endmodule : adcs_host_model

/* sim/adcs_port_chk.sv */
// Concurrent checks on the converter serial port pins and pulses
`timescale 1ns/10ps
module adcs_port_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk_pin,
    input wire logic start_select_line,
    input wire logic sdo_o,
    input wire logic sdo_oe_n,
    input wire logic clamp_event,
    input wire logic status_bits_en,
    input wire logic span_comp_en,
    input wire logic high_z_en,
    input wire logic turbo_en,
    input wire logic input_clamp_event_flag_n,
    input wire logic reg_write_done,
    input wire logic frame_ignored
);
    logic [1:0] sck_q;
    logic [1:0] sel_q;
    logic [4:0] rise_q;
    logic [4:0] fall_q;
    logic [4:0] since_q;
    logic       stat_q;
    logic       fall_evt;
    logic       rise_evt;
    logic       sel_fell;
    assign fall_evt = sck_q[1] & ~sck_q[0];
    assign rise_evt = ~sck_q[1] & sck_q[0];
    assign sel_fell = sel_q[1] & ~sel_q[0];
    // Pins are async, so edges are counted from sampled copies
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_q <= 2'h0;
            sel_q <= 2'h3;
            rise_q <= 5'h0;
            fall_q <= 5'h0;
            since_q <= 5'h1f;
            stat_q <= 1'b0;
        end else begin
            sck_q <= {sck_q[0], sclk_pin};
            sel_q <= {sel_q[0], start_select_line};
            rise_q <= sel_q[0] ? 5'h0 : rise_q + 5'(rise_evt);
            fall_q <= sel_q[0] ? 5'h0 : fall_q + 5'(fall_evt);
            since_q <= (fall_evt | sel_fell) ? 5'h0 : since_q + 5'(since_q != 5'h1f);
            stat_q <= sel_fell ? status_bits_en : stat_q;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_rel; sel_q[0] [*6] |-> sdo_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("output not released");
    property p_fall; !sdo_oe_n && $past(!sdo_oe_n) && $changed(sdo_o) |-> since_q <= 5'h06; endproperty
    a_fall: assert property (p_fall) else $error("output moved off a falling edge");
    property p_wr16; reg_write_done |-> rise_q == 5'h10; endproperty
    a_wr16: assert property (p_wr16) else $error("write applied early");
    property p_ign; frame_ignored |-> rise_q == 5'h08; endproperty
    a_ign: assert property (p_ign) else $error("ignore pulse misplaced");
    property p_cfg; $changed({status_bits_en, span_comp_en, high_z_en, turbo_en})
        |-> reg_write_done || $past(reg_write_done); endproperty
    a_cfg: assert property (p_cfg) else $error("config moved without write");
    property p_fset; clamp_event |-> ##[0:2] !input_clamp_event_flag_n; endproperty
    a_fset: assert property (p_fset) else $error("clamp flag not set");
    property p_frest; $rose(input_clamp_event_flag_n) |-> rise_q == 5'h0f && !$past(clamp_event); endproperty
    a_frest: assert property (p_frest) else $error("clamp flag cleared off a read");
    property p_srel; fall_evt && fall_q == (stat_q ? 5'h15 : 5'h0f) |-> ##[1:6] sdo_oe_n; endproperty
    a_srel: assert property (p_srel) else $error("no release after last bit");
endmodule : adcs_port_chk
bind adcs_port adcs_port_chk u_adcs_port_chk (.clk(clk), .rst_n(rst_n), .sclk_pin(sclk_pin),
    .start_select_line(start_select_line), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .clamp_event(clamp_event),
    .status_bits_en(status_bits_en), .span_comp_en(span_comp_en), .high_z_en(high_z_en), .turbo_en(turbo_en),
    .input_clamp_event_flag_n(input_clamp_event_flag_n), .reg_write_done(reg_write_done),
    .frame_ignored(frame_ignored));

/* sim/testbench.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/10ps
module testbench;
    import adcs_pkg::*;
    logic clk, rst_n, conv_valid, conv_ready, clamp_event, go, done;
    logic sclk_pin, start_select_line, sdi_pin, sdo_o, sdo_oe_n;
    logic status_bits_en, span_comp_en, high_z_en, turbo_en, input_clamp_event_flag_n;
    logic reg_write_done, frame_ignored;
    logic [15:0] conv_data, res;
    logic [15:0] q[$];
    logic [21:0] tx, rx;
    logic [4:0]  nbits;
    logic [7:0]  bad [5] = '{8'h94, 8'h15, 8'h04, 8'h34, 8'h1c};
    int miscompares, check_count, cycles;
    adcs_port u_adcs_port (.clk(clk), .rst_n(rst_n), .sclk_pin(sclk_pin), .start_select_line(start_select_line),
        .sdi_pin(sdi_pin), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .conv_data(conv_data), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .clamp_event(clamp_event), .conv_start(), .status_bits_en(status_bits_en),
        .span_comp_en(span_comp_en), .high_z_en(high_z_en), .turbo_en(turbo_en),
        .input_clamp_event_flag_n(input_clamp_event_flag_n), .reg_write_done(reg_write_done),
        .frame_ignored(frame_ignored));
    adcs_host_model u_adcs_host_model (.go(go), .nbits(nbits), .tx(tx), .rx(rx), .done(done),
        .sclk_pin(sclk_pin), .start_select_line(start_select_line), .sdi_pin(sdi_pin), .sdo_o(sdo_o),
        .sdo_oe_n(sdo_oe_n));
    // Clock source
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, well above the roughly six thousand cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk_vec(input logic [21:0] got, input logic [21:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_vec
    // Config outputs as {status, span, high-z, turbo, flag}
    task automatic chk_cfg(input logic [4:0] exp);
        check_count++;
        if ({status_bits_en, span_comp_en, high_z_en, turbo_en, input_clamp_event_flag_n} !== exp) begin
            miscompares++;
            $display("ERROR %0t config exp %h", $time, exp);
        end
    endtask : chk_cfg
    // Valid stays up between words; dropped only with the last one
    task automatic push(input logic [15:0] w, input logic last);
        conv_data <= w;
        conv_valid <= 1'b1;
        @(negedge clk);
        while (!conv_ready) @(negedge clk);
        @(posedge clk);
        if (last) conv_valid <= 1'b0;
        q.push_back(w);
    endtask : push
    // Frame pops one result, or repeats the last one when empty
    task automatic frame(input logic [21:0] t, input logic [4:0] n);
        tx <= t;
        nbits <= n;
        go <= 1'b1;
        @(posedge clk);
        while (!done) @(posedge clk);
        go <= 1'b0;
        if (q.size() > 0) res = q.pop_front();
        repeat (2) @(posedge clk);
    endtask : frame
    task automatic t_write();
        push(16'ha5c3, 1'b1);
        frame({8'h14, 8'h1e, 6'h3f}, 5'd16);
        chk_vec({6'h0, rx[21:6]}, {6'h0, res}, "result");
        chk_cfg(5'h1f);
        chk_vec({21'h0, sdo_oe_n}, 22'h1, "release");
        $display("write test done");
    endtask : t_write
    task automatic t_read();
        push(16'h1234, 1'b1);
        frame({8'h54, 8'h00, 6'h00}, 5'd22);
        chk_vec(rx, {8'h12, 8'h1f, 6'h3c}, "read frame");
        chk_cfg(5'h1f);
        chk_vec({21'h0, sdo_oe_n}, 22'h1, "release");
        $display("read test done");
    endtask : t_read
    task automatic t_bad();
        foreach (bad[i]) begin
            frame({bad[i], 8'h00, 6'h00}, 5'd16);
            chk_vec({6'h0, rx[21:6]}, {6'h0, res}, "result");
            chk_cfg(5'h1f);
        end
        $display("bad command test done");
    endtask : t_bad
    task automatic t_clamp();
        clamp_event <= 1'b1;
        @(posedge clk);
        clamp_event <= 1'b0;
        repeat (3) @(posedge clk);
        chk_cfg(5'h1e);
        frame(22'h3fffff, 5'd18);
        chk_vec({20'h0, rx[5:4]}, 22'h1, "status head");
        chk_vec({21'h0, sdo_oe_n}, 22'h1, "release");
        chk_cfg(5'h1e);
        frame({8'h54, 8'h00, 6'h00}, 5'd16);
        chk_vec({14'h0, rx[13:6]}, 22'h1e, "flag read");
        chk_cfg(5'h1f);
        $display("clamp test done");
    endtask : t_clamp
    // Fill the buffer until it refuses, then drain it through slow frames
    task automatic t_fifo();
        for (int i = 0; i < FIFO_DEPTH; i++) push(16'h0100 + 16'(i), i == FIFO_DEPTH - 1);
        @(negedge clk);
        chk_vec({21'h0, conv_ready}, 22'h0, "full");
        @(posedge clk);
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            frame(22'h3fffff, 5'd16);
            chk_vec({6'h0, rx[21:6]}, {6'h0, 16'h0100 + 16'(i == FIFO_DEPTH ? i - 1 : i)}, "drain");
        end
        chk_vec({21'h0, conv_ready}, 22'h1, "empty");
        $display("buffer test done");
    endtask : t_fifo
    // Main sequence
    initial begin
        rst_n = 1'b0;
        conv_valid = 1'b0;
        conv_data = 16'h0;
        clamp_event = 1'b0;
        go = 1'b0;
        tx = 22'h0;
        nbits = 5'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_cfg(5'h01);
        chk_vec({21'h0, sdo_oe_n}, 22'h1, "idle release");
        $display("reset test done");
        t_write();
        t_read();
        t_bad();
        t_clamp();
        t_fifo();
        close_out();
    end
endmodule : testbench
